//--- logic/tbc_control.sv
// Two-wire bus controller: registers, master engine and line drivers
//
// Behaviour
// - Code 0x20 gives divider 160 and hold counts 17, 78, 81.
// - Code 0x3F gives divider 3840 and hold counts 513, 1918, 1921.
// - The bus interface works only while the enable bit is set.
// - Interrupt requests reach the output only while interrupt enable is set.
// - Master select rising makes a start condition and enters master mode.
// - Master select falling makes a stop condition and returns to slave; this design has no slave mode and goes back to idle.
// - Direction bit: 0 receives, 1 transmits, master and slave alike; this design has master transfers only.
// - As receiver, acknowledge cycle drives the ack suppress bit onto data.
// - Writing repeat start while master makes a repeated start.
// - The repeat start request bit always reads back zero.
// - Repeat start at an improper point counts as lost arbitration.
// - Bit rate is clock over scale factor times divider.
// - Data, start and stop holds are clock periods times factor times count.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`default_nettype none
module tbc_control
(
	input	wire logic			clk,
	input	wire logic			rstn,
	input	wire logic [tbc_pkg::AW-1:0]	addr,
	input	wire logic [tbc_pkg::DW-1:0]	wdata,
	input	wire logic			wr,
	input	wire logic			rd,
	output	logic [tbc_pkg::DW-1:0]		rdata,
	input	wire logic			sclIn,
	output	logic				sclOut,
	output	logic				sclOe,
	input	wire logic			sdaIn,
	output	logic				sdaOut,
	output	logic				sdaOe,
	output	logic				irq
);
	import tbc_pkg::*;

	typedef struct packed {
		tbc_state_t		st;
		logic [DW-1:0]		rate;
		logic [DW-1:0]		ctrl;
		logic [DW-1:0]		txSh;
		logic [DW-1:0]		rxByte;
		logic [DW-1:0]		rdata;
		logic [3:0]		bitNo;
		logic [CNTW-1:0]	cnt;
		logic			done;
		logic			busy;
		logic			arb;
		logic			irqF;
		logic			nack;
		logic			sclLow;
		logic			sdaLow;
		logic			sclPrev;
		logic			sdaPrev;
	} tbc_regs_t;

	localparam tbc_regs_t	REGS_RESET = '{
		st: TBC_IDLE,
		rate: RATE_RESET,
		ctrl: CTRL_RESET,
		sclPrev: 1'b1,
		sdaPrev: 1'b1,
		default: '0
	};

	tbc_regs_t		s;
	tbc_regs_t		next_s;
	tbc_rate_if		rif ();
	logic [DW-1:0]		statusByte;
	logic			wrRate;
	logic			wrCtrl;
	logic			wrStat;
	logic			wrData;
	logic			rdData;
	logic			txMode;
	logic			rsHit;
	logic			lose;

	tbc_rate u_rate
	(
		.rif	(rif.rate)
	);

	assign rif.rateReg = s.rate;
	assign wrRate = wr && addr == OFS_RATE;
	assign wrCtrl = wr && addr == OFS_CTRL;
	assign wrStat = wr && addr == OFS_STAT;
	assign wrData = wr && addr == OFS_DATA;
	assign rdData = rd && addr == OFS_DATA;
	// Direction taken from the control register
	assign txMode = s.ctrl[CTRL_TX];
	// Repeat start only counts while master
	assign rsHit = wrCtrl && wdata[CTRL_REPEAT_START_REQUEST] && s.ctrl[CTRL_MS] && s.ctrl[CTRL_EN];

	always_comb
	begin
		statusByte = 8'h00;
		statusByte[ST_DONE] = s.done;
		statusByte[ST_BUSY] = s.busy;
		statusByte[ST_ARB] = s.arb;
		statusByte[ST_IRQ] = s.irqF;
		statusByte[ST_NACK] = s.nack;
	end

	always_comb
	begin
		next_s = s;
		lose = 1'b0;
		next_s.rdata = 8'h00;
		next_s.sclPrev = sclIn;
		next_s.sdaPrev = sdaIn;
		next_s.cnt = s.cnt + CNTW'(1);

		// Start and stop seen on the lines, whoever made them
		if (sclIn && s.sclPrev && s.sdaPrev && !sdaIn)
			next_s.busy = 1'b1;
		else if (sclIn && s.sclPrev && !s.sdaPrev && sdaIn)
			next_s.busy = 1'b0;

		if (rd)
		begin
			unique case (addr)
				OFS_RATE: next_s.rdata = s.rate;
				OFS_CTRL: next_s.rdata = s.ctrl;
				OFS_STAT: next_s.rdata = statusByte;
				OFS_DATA: next_s.rdata = s.rxByte;
			endcase
		end

		if (wrRate)
			next_s.rate = wdata;
		if (wrCtrl)
		begin
			next_s.ctrl = wdata;
			next_s.ctrl[CTRL_REPEAT_START_REQUEST] = 1'b0;
		end
		// Clears come first so that a set in the same cycle wins
		if (wrStat && wdata[ST_ARB])
			next_s.arb = 1'b0;
		if (wrStat && wdata[ST_IRQ])
			next_s.irqF = 1'b0;
		if ((wrData && txMode) || (rdData && !txMode))
			next_s.done = 1'b0;

		unique case (s.st)
			TBC_IDLE:
			begin
				next_s.cnt = '0;
				next_s.sclLow = 1'b0;
				next_s.sdaLow = 1'b0;
				if (s.ctrl[CTRL_EN] && s.ctrl[CTRL_MS])
				begin
					// Someone else owns the bus: give up at once
					if (s.busy)
						lose = 1'b1;
					else
					begin
						next_s.st = TBC_START;
						next_s.sdaLow = 1'b1;
					end
				end
			end
			TBC_START:
			begin
				if (s.cnt == rif.startHold)
				begin
					next_s.sclLow = 1'b1;
					next_s.st = TBC_WAIT;
					next_s.cnt = '0;
				end
			end
			TBC_WAIT:
			begin
				// Clock held low until software acts
				if (s.cnt == rif.sdaHold)
					next_s.sdaLow = 1'b0;
				if (!s.ctrl[CTRL_MS])
				begin
					// Stop once master select is cleared
					next_s.st = TBC_STOP;
					next_s.sdaLow = 1'b1;
					next_s.cnt = '0;
				end
				else if (rsHit)
				begin
					next_s.st = TBC_RSTART;
					next_s.sdaLow = 1'b0;
					next_s.cnt = '0;
				end
				else if (wrData && txMode)
				begin
					next_s.txSh = wdata;
					next_s.bitNo = 4'h0;
					next_s.st = TBC_BITLO;
					next_s.cnt = '0;
				end
				else if (rdData && !txMode)
				begin
					next_s.bitNo = 4'h0;
					next_s.st = TBC_BITLO;
					next_s.cnt = '0;
				end
			end
			TBC_BITLO:
			begin
				// Data changes one hold count after clock fell
				if (s.cnt == rif.sdaHold)
				begin
					if (s.bitNo == BITS_PER_BYTE)
						// Receiver answers with the ack suppress bit
						next_s.sdaLow = txMode ? 1'b0 : !s.ctrl[CTRL_ACKS];
					else
						next_s.sdaLow = txMode ? !s.txSh[DW-1] : 1'b0;
				end
				// Low half of the bit period
				if (s.cnt == rif.sclHalf - CNTW'(1))
				begin
					next_s.sclLow = 1'b0;
					next_s.st = TBC_BITHI;
					next_s.cnt = '0;
				end
			end
			TBC_BITHI:
			begin
				// A slave stretching the clock holds the count at zero
				if (!sclIn)
					next_s.cnt = '0;
				else if (s.cnt == '0)
				begin
					if (s.bitNo == BITS_PER_BYTE)
					begin
						if (txMode)
							next_s.nack = sdaIn;
						else
							next_s.rxByte = s.txSh;
					end
					else
					begin
						next_s.txSh = {s.txSh[DW-2:0], sdaIn};
						// Released a one but the line reads zero
						if (txMode && !s.sdaLow && !sdaIn)
							lose = 1'b1;
					end
				end
				else if (s.cnt == rif.sclHalf - CNTW'(1))
				begin
					next_s.sclLow = 1'b1;
					next_s.cnt = '0;
					next_s.bitNo = s.bitNo + 4'h1;
					if (s.bitNo == BITS_PER_BYTE)
					begin
						next_s.st = TBC_WAIT;
						next_s.done = 1'b1;
						next_s.irqF = 1'b1;
					end
					else
						next_s.st = TBC_BITLO;
				end
			end
			TBC_STOP:
			begin
				if (s.cnt == rif.sclHalf)
					next_s.sclLow = 1'b0;
				// Stop hold from clock rise to data rise
				if (s.cnt == rif.sclHalf + rif.stopHold)
				begin
					next_s.sdaLow = 1'b0;
					next_s.st = TBC_IDLE;
				end
			end
			TBC_RSTART:
			begin
				if (s.cnt == rif.sclHalf)
					next_s.sclLow = 1'b0;
				if (s.cnt == (rif.sclHalf << 1))
					next_s.sdaLow = 1'b1;
				if (s.cnt == (rif.sclHalf << 1) + rif.startHold)
				begin
					next_s.sclLow = 1'b1;
					next_s.st = TBC_WAIT;
					next_s.cnt = '0;
				end
			end
			default:
				next_s.st = TBC_IDLE;
		endcase

		// Repeat start in the middle of a sequence
		if (rsHit && s.st != TBC_WAIT && s.st != TBC_IDLE)
			lose = 1'b1;
		if (lose)
		begin
			next_s.arb = 1'b1;
			next_s.irqF = 1'b1;
			next_s.ctrl[CTRL_MS] = 1'b0;
			next_s.st = TBC_IDLE;
			next_s.sclLow = 1'b0;
			next_s.sdaLow = 1'b0;
		end
		if (!s.ctrl[CTRL_EN])
		begin
			next_s.st = TBC_IDLE;
			next_s.sclLow = 1'b0;
			next_s.sdaLow = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			s <= REGS_RESET;
		else
			s <= next_s;
	end

	// Open-drain lines only ever pull low
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = s.sclLow;
	assign sdaOe = s.sdaLow;
	assign rdata = s.rdata;
	assign irq = s.irqF && s.ctrl[CTRL_IE];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence startAsked;
		s.st == TBC_IDLE && s.ctrl[CTRL_EN] && s.ctrl[CTRL_MS] && !s.busy;
	endsequence
	sequence startDriven;
		s.st == TBC_START && sdaOe && !sclOe;
	endsequence
	sequence stopAsked;
		s.st == TBC_WAIT && s.ctrl[CTRL_EN] && !s.ctrl[CTRL_MS];
	endsequence
	sequence byteEnd;
		s.st == TBC_BITHI && s.ctrl[CTRL_EN] ##1 s.st == TBC_WAIT;
	endsequence

	rate_code20_a: assert property (
		s.rate == 8'h20 |-> rif.sclHalf == 16'h0050 && rif.sdaHold == 16'h0011
			&& rif.startHold == 16'h004e && rif.stopHold == 16'h0051)
		else $error("wrong counts for code 20");
	rate_code3f_a: assert property (
		s.rate == 8'h3f |-> rif.sclHalf == 16'h0780 && rif.sdaHold == 16'h0201
			&& rif.startHold == 16'h077e && rif.stopHold == 16'h0781)
		else $error("wrong counts for code 3f");
	disabled_idle_a: assert property (
		!s.ctrl[CTRL_EN] |=> s.st == TBC_IDLE && !sclOe && !sdaOe)
		else $error("lines driven while disabled");
	byte_irq_a: assert property (
		byteEnd |-> s.done && irq == s.ctrl[CTRL_IE])
		else $error("interrupt request not gated by enable");
	start_gen_a: assert property (
		startAsked |=> startDriven)
		else $error("start condition not generated");
	start_hold_a: assert property (
		$rose(sclOe) && $past(s.st) == TBC_START |-> $past(s.cnt) == rif.startHold)
		else $error("start hold count wrong");
	stop_gen_a: assert property (
		stopAsked |=> s.st == TBC_STOP && sdaOe)
		else $error("stop condition not started");
	tx_start_a: assert property (
		s.st == TBC_WAIT && s.ctrl[CTRL_EN] && s.ctrl[CTRL_MS] && !rsHit && wrData
			&& txMode |=> s.st == TBC_BITLO && s.txSh == $past(wdata))
		else $error("transmit byte not started");
	ack_drive_a: assert property (
		s.st == TBC_BITLO && s.ctrl[CTRL_EN] && !rsHit && s.bitNo == BITS_PER_BYTE
			&& !txMode && s.cnt == rif.sdaHold |=> sdaOe == !$past(s.ctrl[CTRL_ACKS]))
		else $error("acknowledge not driven from control");
	half_period_a: assert property (
		$fell(sclOe) && $past(s.st) == TBC_BITLO && s.st == TBC_BITHI
			|-> $past(s.cnt) == rif.sclHalf - 16'h0001)
		else $error("clock low half wrong length");
	repeat_start_request_read_a: assert property (
		rd && addr == OFS_CTRL |=> !rdata[CTRL_REPEAT_START_REQUEST] ##1 ($past(rd) || rdata == 8'h00))
		else $error("repeat start bit read back set");
	repeat_start_request_ok_a: assert property (
		rsHit && s.st == TBC_WAIT |=> s.st == TBC_RSTART && !sdaOe)
		else $error("repeated start not begun");
	repeat_start_request_lose_a: assert property (
		rsHit && (s.st == TBC_BITLO || s.st == TBC_BITHI)
			|=> s.arb && s.irqF && !s.ctrl[CTRL_MS] && s.st == TBC_IDLE)
		else $error("misplaced repeat start not lost");
endmodule
`default_nettype wire

//--- logic/tbc_pkg.sv
// Constants and types shared by the two-wire bus controller
`default_nettype none
package tbc_pkg;
	localparam int		AW = 2;
	localparam int		DW = 8;
	localparam int		CNTW = 16;

	localparam logic [AW-1:0]	OFS_RATE = 2'h0;
	localparam logic [AW-1:0]	OFS_CTRL = 2'h1;
	localparam logic [AW-1:0]	OFS_STAT = 2'h2;
	localparam logic [AW-1:0]	OFS_DATA = 2'h3;

	localparam logic [DW-1:0]	RATE_RESET = 8'h00;
	localparam logic [DW-1:0]	CTRL_RESET = 8'h00;

	localparam int		CTRL_EN = 7;
	localparam int		CTRL_IE = 6;
	localparam int		CTRL_MS = 5;
	localparam int		CTRL_TX = 4;
	localparam int		CTRL_ACKS = 3;
	localparam int		CTRL_REPEAT_START_REQUEST = 2;

	localparam int		ST_DONE = 7;
	localparam int		ST_BUSY = 5;
	localparam int		ST_ARB = 4;
	localparam int		ST_IRQ = 1;
	localparam int		ST_NACK = 0;

	localparam logic [3:0]	BITS_PER_BYTE = 4'h8;

	// Scale factor field; the reserved code acts as the largest factor
	localparam logic [1:0]	RATE_SCALE_FACTOR_RSVD = 2'h3;
	localparam logic [1:0]	RATE_SCALE_FACTOR_MAX_SHIFT = 2'h2;

	// Codes below this group have their own tables, above they double per group
	localparam logic [2:0]	GROUP_HIGH = 3'h3;
	localparam logic [7:0]	SCL_LOW [24] = '{
		8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e, 8'h22, 8'h28,
		8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h38, 8'h44,
		8'h30, 8'h38, 8'h40, 8'h48, 8'h50, 8'h58, 8'h68, 8'h80};
	localparam logic [7:0]	SDA_LOW [24] = '{
		8'h07, 8'h07, 8'h08, 8'h08, 8'h09, 8'h09, 8'h0a, 8'h0a,
		8'h07, 8'h07, 8'h09, 8'h09, 8'h0b, 8'h0b, 8'h0d, 8'h0d,
		8'h09, 8'h09, 8'h0d, 8'h0d, 8'h11, 8'h11, 8'h15, 8'h15};
	// Start hold is half the divider less this, per group (last entry: upper groups)
	localparam logic [3:0]	START_OFS [4] = '{4'h4, 4'h4, 4'h6, 4'h2};
	localparam logic [3:0]	SCL_MANT [8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc, 4'hf};
	localparam logic [2:0]	HOLD_MANT [8] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4};
	localparam logic [11:0]	STOP_OFS = 12'h001;

	typedef enum logic [2:0] {
		TBC_IDLE = 3'h0,
		TBC_START = 3'h1,
		TBC_WAIT = 3'h3,
		TBC_BITLO = 3'h2,
		TBC_BITHI = 3'h6,
		TBC_STOP = 3'h7,
		TBC_RSTART = 3'h5
	} tbc_state_t;
endpackage
`default_nettype wire

//--- logic/tbc_rate.sv
// Rate code decoder: scaled half period and hold counts in clock cycles
`default_nettype none
module tbc_rate
(
	tbc_rate_if.rate	rif
);
	import tbc_pkg::*;

	logic [2:0]	grp;
	logic [2:0]	idx;
	logic [1:0]	shift;
	logic [11:0]	div;
	logic [9:0]	sda;
	logic [11:0]	startRaw;

	assign grp = rif.rateReg[5:3];
	assign idx = rif.rateReg[2:0];
	assign shift = (rif.rateReg[7:6] == RATE_SCALE_FACTOR_RSVD) ? RATE_SCALE_FACTOR_MAX_SHIFT : rif.rateReg[7:6];

	always_comb
	begin
		if (grp < GROUP_HIGH)
		begin
			div = {4'h0, SCL_LOW[rif.rateReg[4:0]]};
			sda = {2'h0, SDA_LOW[rif.rateReg[4:0]]};
			startRaw = (div >> 1) - {8'h00, START_OFS[grp[1:0]]};
		end
		else
		begin
			div = 12'(12'(SCL_MANT[idx]) << ({1'b0, grp} + 4'h1));
			sda = 10'(10'(HOLD_MANT[idx]) << grp) + 10'h001;
			startRaw = (div >> 1) - {8'h00, START_OFS[3]};
		end
	end

	// Scale factor applied to every count
	assign rif.sclHalf = (CNTW'(div) << shift) >> 1;
	// Hold counts scaled the same way
	assign rif.sdaHold = CNTW'(sda) << shift;
	assign rif.startHold = CNTW'(startRaw) << shift;
	assign rif.stopHold = CNTW'((div >> 1) + STOP_OFS) << shift;
endmodule
`default_nettype wire

//--- logic/tbc_rate_if.sv
// Link between the control core and the rate decoder
`default_nettype none
interface tbc_rate_if;
	import tbc_pkg::*;
	logic [DW-1:0]		rateReg;
	logic [CNTW-1:0]	sclHalf;
	logic [CNTW-1:0]	sdaHold;
	logic [CNTW-1:0]	startHold;
	logic [CNTW-1:0]	stopHold;
	modport ctrl (output rateReg, input sclHalf, sdaHold, startHold, stopHold);
	modport rate (input rateReg, output sclHalf, sdaHold, startHold, stopHold);
endinterface
`default_nettype wire

//--- testbench/i2c_control_and_rate_test.sv
// Self-checking bench for the two-wire bus controller
`default_nettype none
module i2c_control_and_rate_test;
	timeunit 1ns;
	timeprecision 1ps;
	import tbc_pkg::*;
	logic			clk = 1'b0;
	logic			rstn = 1'b0;
	logic [AW-1:0]		addr = '0;
	logic [DW-1:0]		wdata = '0;
	logic			wr = 1'b0;
	logic			rd = 1'b0;
	logic [DW-1:0]		rdata;
	logic			sclOe, sdaOe, sclOut, sdaOut, irq, sclPull, sdaPull, gotAck;
	// Open-drain pins: an enabled driver shows its output level
	wire			scl = (sclOe ? sclOut : 1'b1) && !sclPull;
	wire			sda = (sdaOe ? sdaOut : 1'b1) && !sdaPull;
	logic			ackOn = 1'b1, txMode = 1'b0;
	logic [7:0]		txByte = '0, stretch = '0, gotByte, startCount, v, b;
	int			fail_count = 0, tests_run = 0, n, p;
	always #5 clk = ~clk;
	tbc_control uut
	(
		.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq)
	);
	tbc_bus_partner peer
	(
		.clk(clk), .scl(scl), .sda(sda), .ackOn(ackOn), .txMode(txMode),
		.txByte(txByte), .stretch(stretch), .sclPull(sclPull), .sdaPull(sdaPull),
		.gotByte(gotByte), .gotAck(gotAck), .startCount(startCount)
	);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		if (fail_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic give_up;
		fail_count++;
		give_verdict;
	endtask
	task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	// Counts cycles until one line driver reaches the given level
	task automatic wait_oe(input bit onScl, input logic val, output int cnt);
		cnt = 0;
		while ((onScl ? sclOe : sdaOe) !== val && cnt < 20000)
		begin
			@(negedge clk);
			cnt++;
		end
		if (cnt >= 20000)
			give_up;
	endtask
	task automatic wait_stat(input int bitNo, input logic val);
		int k = 0;
		rd_reg(OFS_STAT, v);
		while (v[bitNo] !== val && k < 5000)
		begin
			rd_reg(OFS_STAT, v);
			k++;
		end
		if (k >= 5000)
			give_up;
	endtask
	// Scale field 3 behaves as the largest factor
	function automatic int scaled(input int cnt, input logic [1:0] sc);
		return cnt * ((sc == 2'h0) ? 1 : (sc == 2'h1) ? 2 : 4);
	endfunction
	// Register stages add up to three cycles beyond the ideal figure
	function automatic logic [15:0] near(input int seen, input int exp);
		return 16'(seen >= exp && seen <= exp + 3);
	endfunction
	initial
	begin
		void'($urandom(32'hf43b3620));
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk(16'({sclOe, sdaOe}), 16'h0); // lines released
		for (int i = 0; i < 4; i++)
		begin
			rd_reg(AW'(i), v);
			chk(16'(v), 16'h0); // idle after reset
		end
		for (int i = 0; i < 6; i++)
		begin
			p = $urandom;
			// Corner codes at scale one among the random ones
			if (i < 2)
				p[7:0] = (i == 0) ? 8'h20 : 8'h3f;
			wr_reg(OFS_RATE, p[7:0]);
			rd_reg(OFS_RATE, v);
			chk(16'(v), 16'(p[7:0])); // rate readback
			// Enable and master select stay low so no traffic starts
			wr_reg(OFS_CTRL, (p[15:8] & 8'h5f) | 8'h04);
			rd_reg(OFS_CTRL, v);
			chk(16'(v), 16'(p[15:8] & 8'h5b)); // reads zero
		end
		wr_reg(OFS_CTRL, 8'h34);
		n = 0;
		repeat (60)
		begin
			@(negedge clk);
			n += int'(sclOe !== 1'b0 || sdaOe !== 1'b0);
		end
		chk(16'(n), 16'h0); // disabled lines
		chk(16'(uut.rdata), 16'h0); // nothing pending
		wr_reg(OFS_CTRL, 8'h00);
		// Reserved scale field must act as the largest factor
		wr_reg(OFS_RATE, 8'hff);
		wr_reg(OFS_CTRL, 8'hb0); // address at transmit
		wait_oe(1'b0, 1'b1, n);
		wait_oe(1'b1, 1'b1, n);
		chk(near(n, scaled(1918, 2'h3)), 16'h1); // start hold
		rd_reg(OFS_STAT, v);
		chk(16'(v[5]), 16'h1); // bus busy
		wr_reg(OFS_CTRL, 8'h90);
		wait_oe(1'b1, 1'b0, n);
		wait_oe(1'b0, 1'b0, n);
		chk(near(n, scaled(1921, 2'h3)), 16'h1); // stop hold
		wait_stat(5, 1'b0);
		chk(16'(v[5]), 16'h0); // bus freed
		wr_reg(OFS_RATE, 8'h60);
		wr_reg(OFS_CTRL, 8'hf0);
		wait_oe(1'b0, 1'b1, n);
		wait_oe(1'b1, 1'b1, n);
		chk(near(n, scaled(78, 2'h1)), 16'h1); // start hold
		for (int i = 0; i < 2; i++)
		begin
			ackOn = (i == 0);
			b = {2'b10, 6'($urandom)};
			wr_reg(OFS_DATA, b);
			wait_oe(1'b1, 1'b0, n);
			wait_oe(1'b1, 1'b1, n);
			wait_oe(1'b0, 1'b1, p);
			chk(near(p, scaled(17, 2'h1)), 16'h1); // data hold
			n += p;
			wait_oe(1'b1, 1'b0, p);
			chk(near(n + p, scaled(160, 2'h1)), 16'h1); // bit period
			wait_stat(7, 1'b1);
			chk(16'(gotByte), 16'(b)); // byte sent
			chk(16'(v & 8'h83), 16'(8'h82 | 8'(i))); // flags set
			chk(16'(irq), 16'h1); // request raised
			wr_reg(OFS_CTRL, 8'hb0);
			chk(16'(irq), 16'h0); // request masked
			wr_reg(OFS_CTRL, 8'hf0);
			chk(16'(irq), 16'h1); // request unmasked
			wr_reg(OFS_STAT, 8'h02);
			chk(16'(irq), 16'h0); // flag cleared
		end
		stretch = 8'd200;
		txMode = 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			txByte = 8'($urandom);
			wr_reg(OFS_CTRL, 8'ha0 | 8'(i << 3)); // direction matches transfer
			rd_reg(OFS_DATA, v);
			wait_stat(7, 1'b1);
			chk(16'(gotAck), 16'(i)); // ack driven
			// Direction flips first so the read starts no new byte
			wr_reg(OFS_CTRL, 8'hb0);
			rd_reg(OFS_DATA, v);
			chk(16'(v), 16'(txByte)); // byte received
		end
		stretch = 8'd0;
		txMode = 1'b0;
		n = int'(startCount);
		wr_reg(OFS_CTRL, 8'hb4);
		wait_oe(1'b0, 1'b1, p);
		wait_oe(1'b1, 1'b1, p);
		chk(16'(startCount - n[7:0]), 16'h1); // repeated start
		rd_reg(OFS_CTRL, v);
		chk(16'(v), 16'hb0); // reads zero
		wr_reg(OFS_DATA, 8'h5a);
		wait_oe(1'b1, 1'b0, p);
		wr_reg(OFS_CTRL, 8'hb4);
		rd_reg(OFS_STAT, v);
		chk(16'(v[4]), 16'h1); // arbitration lost
		rd_reg(OFS_CTRL, v);
		chk(16'(v[5]), 16'h0); // master dropped
		chk(16'({sclOe, sdaOe}), 16'h0); // lines released
		wr_reg(OFS_STAT, 8'h12);
		rd_reg(OFS_STAT, v);
		chk(16'(v[4]), 16'h0); // flag cleared
		give_verdict;
	end
endmodule
`default_nettype wire

//--- testbench/tbc_bus_partner.sv
// Far-side bus party: acks, sends bytes and stretches the clock
`default_nettype none
module tbc_bus_partner
(
	input	wire logic		clk,
	input	wire logic		scl,
	input	wire logic		sda,
	input	wire logic		ackOn,
	input	wire logic		txMode,
	input	wire logic [7:0]	txByte,
	input	wire logic [7:0]	stretch,
	output	logic			sclPull,
	output	logic			sdaPull,
	output	logic [7:0]		gotByte,
	output	logic			gotAck,
	output	logic [7:0]		startCount
);
	timeunit 1ns;
	timeprecision 1ps;
	logic		sclQ = 1'b1;
	logic		sdaQ = 1'b1;
	logic		active = 1'b0;
	logic [3:0]	bitCnt = 4'h0;
	logic [7:0]	hold = 8'h00;
	initial
	begin
		sdaPull = 1'b0;
		gotByte = 8'h00;
		gotAck = 1'b1;
		startCount = 8'h00;
	end
	// Stretching only bites when it outlasts the master's own low phase
	assign sclPull = hold != 8'h00;
	always @(posedge clk)
	begin
		sclQ <= scl;
		sdaQ <= sda;
		if (sclQ && scl && sdaQ && !sda)
		begin
			startCount <= startCount + 8'h01;
			bitCnt <= 4'h0;
			active <= 1'b1;
		end
		else if (!sclQ && scl)
		begin
			if (bitCnt == 4'h8)
			begin
				gotAck <= sda;
				// A refused byte ends our sending until the next start
				if (txMode && sda)
					active <= 1'b0;
				bitCnt <= 4'h0;
			end
			else
			begin
				gotByte <= {gotByte[6:0], sda};
				bitCnt <= bitCnt + 4'h1;
			end
		end
		if (sclQ && !scl)
			hold <= stretch;
		else if (hold != 8'h00)
			hold <= hold - 8'h01;
		// Data changes only while the clock line is low
		if (!scl)
			sdaPull <= active && ((bitCnt == 4'h8) ? (!txMode && ackOn)
				: (txMode && !txByte[3'h7 - bitCnt[2:0]]));
	end
endmodule
`default_nettype wire
